// ===== ccr_pkg.sv
// package: register map, field positions and codes of the comparator control block
// Summary of operation
// - after reset every bit reads zero: both comparators off, unlocked
// - second lock bit 31 sets once by software, cleared only by reset
// - while second lock is one, writes to bits 31..16 are ignored
// - first lock bit 15 sets once; while one, bits 15..0 ignore writes
// - bit 30 mirrors second comparator output, read only
// - bits 29..28 select second comparator hysteresis level
// - bit 27 inverts second comparator output before routing
// - bits 26..24 route second comparator output to one timer input
// - bit 23 joins second positive input to first positive input (window)
// - bits 22..20 select second negative input; code 111 reserved
// - bits 19..18 set second comparator speed/power mode
// - first comparator: hysteresis 13..12, polarity 11, route 10..8, mirror 14
// - bits 6..4 select first negative input; code 111 reserved
// - bits 3..2 first power mode; bit 0 enables first comparator
// - bit 1 closes switch joining first positive pin to converter output
package ccr_pkg;
  localparam logic [11:0] CCR_CS_OFFSET = 12'h000;
  localparam logic [31:0] CCR_CS_RESET = 32'h00000000;
  // writable bits; 30, 17, 14 and 7 are not storable
  localparam logic [31:0] CCR_CS_WMASK = 32'hbffdbf7f;
  localparam int CCR_LOCK1_POS = 31;
  localparam int CCR_OUT1_POS = 30;
  localparam int CCR_LOCK0_POS = 15;
  localparam int CCR_OUT0_POS = 14;
  localparam int CCR_HALF_POS = 16;
  // offsets within one comparator half
  localparam int CCR_EN_POS = 0;
  localparam int CCR_SW_POS = 1;
  localparam int CCR_MODE_POS = 2;
  localparam int CCR_NSEL_POS = 4;
  localparam int CCR_WIN_POS = 7;
  localparam int CCR_ROUTE_POS = 8;
  localparam int CCR_POL_POS = 11;
  localparam int CCR_HYST_POS = 12;
  localparam logic [2:0] CCR_NSEL_RSVD = 3'h7;
  localparam logic [2:0] CCR_ROUTE_NONE = 3'h0;
  localparam int CCR_NUM_ROUTES = 7;
endpackage : ccr_pkg

// ===== ccr_route.sv
// polarity and output routing of one comparator
`timescale 1ns/100ps
module ccr_route
  import ccr_pkg::*;
(
  input wire logic cmp_i,
  input wire logic enable_i,
  input wire logic polarity_i,
  input wire logic [2:0] route_i,
  output logic [CCR_NUM_ROUTES-1:0] dest_o
);
  logic level;
  always_comb begin
    level = enable_i & (cmp_i ^ polarity_i);
    dest_o = '0;
    if (route_i != CCR_ROUTE_NONE) begin
      dest_o[route_i - 3'h1] = level;
    end
  end
endmodule : ccr_route

// ===== ccr_apb.sv
// apb slave front end: zero wait state, decode of the single register
`timescale 1ns/100ps
module ccr_apb
  import ccr_pkg::*;
(
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  output logic wr_o,
  output logic hit_o
);
  always_comb begin
    hit_o = (paddr_i[11:2] == CCR_CS_OFFSET[11:2]);
    wr_o = psel_i & penable_i & pwrite_i & hit_o;
  end
endmodule : ccr_apb

// ===== ccr_top.sv
// comparator control/status register on apb with routed comparator outputs
`timescale 1ns/100ps
module ccr_top
  import ccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic first_cmp_raw_i,
  input wire logic second_cmp_raw_i,
  output logic first_comparator_enable_o,
  output logic second_comparator_enable_o,
  output logic first_comparator_input_switch_o,
  output logic window_pairing_enable_o,
  output logic [1:0] first_comparator_power_mode_o,
  output logic [1:0] second_comparator_power_mode_o,
  output logic [2:0] first_comparator_negative_select_o,
  output logic [2:0] second_comparator_negative_select_o,
  output logic [1:0] first_comparator_hysteresis_o,
  output logic [1:0] second_comparator_hysteresis_o,
  output logic [CCR_NUM_ROUTES-1:0] first_route_o,
  output logic [CCR_NUM_ROUTES-1:0] second_route_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] cs;
    logic [1:0] out;
    logic [31:0] rdata;
    logic slverr;
    logic [CCR_NUM_ROUTES-1:0] route0;
    logic [CCR_NUM_ROUTES-1:0] route1;
  } ccr_state_s;

  ccr_state_s st_r;
  ccr_state_s st_nxt;
  logic wr;
  logic hit;
  logic [CCR_NUM_ROUTES-1:0] dest0;
  logic [CCR_NUM_ROUTES-1:0] dest1;

  ccr_apb u_apb (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .wr_o(wr),
    .hit_o(hit)
  );

  ccr_route u_route0 (
    .cmp_i(first_cmp_raw_i),
    .enable_i(st_r.cs[CCR_EN_POS]),
    .polarity_i(st_r.cs[CCR_POL_POS]),
    .route_i(st_r.cs[CCR_ROUTE_POS +: 3]),
    .dest_o(dest0)
  );

  ccr_route u_route1 (
    .cmp_i(second_cmp_raw_i),
    .enable_i(st_r.cs[CCR_HALF_POS + CCR_EN_POS]),
    .polarity_i(st_r.cs[CCR_HALF_POS + CCR_POL_POS]),
    .route_i(st_r.cs[CCR_HALF_POS + CCR_ROUTE_POS +: 3]),
    .dest_o(dest1)
  );

  // merge one 16-bit half; a locked half keeps its value, reserved codes are refused
  function automatic logic [15:0] ccr_merge(input logic [15:0] cur, input logic [15:0] wdat,
                                            input logic [15:0] wmask);
    logic [15:0] res;
    res = cur;
    if (!cur[15]) begin
      res = (wdat & wmask) | {1'b0, 15'h0000};
      if (wdat[CCR_NSEL_POS +: 3] == CCR_NSEL_RSVD) begin
        // reserved negative-input code leaves the old selection in place
        res[CCR_NSEL_POS +: 3] = cur[CCR_NSEL_POS +: 3];
      end
    end
    ccr_merge = res;
  endfunction : ccr_merge

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.out[0] = st_r.cs[CCR_EN_POS] & first_cmp_raw_i;
    st_nxt.out[1] = st_r.cs[CCR_HALF_POS + CCR_EN_POS] & second_cmp_raw_i;
    st_nxt.route0 = dest0;
    st_nxt.route1 = dest1;
    st_nxt.slverr = 1'b0;
    if (psel_i && !penable_i) begin
      // decided in setup so the error stands through the single access cycle
      if (!hit || (pwrite_i && pstrb_i != 4'hf)) begin
        st_nxt.slverr = 1'b1;
      end
    end
    // partial strobes leave the register untouched
    if (wr && pstrb_i == 4'hf) begin
      st_nxt.cs[31:16] = ccr_merge(st_r.cs[31:16], pwdata_i[31:16], CCR_CS_WMASK[31:16]);
      st_nxt.cs[15:0] = ccr_merge(st_r.cs[15:0], pwdata_i[15:0], CCR_CS_WMASK[15:0]);
      // window bit lives in the upper half only; bit 7 stays reserved
      st_nxt.cs[CCR_WIN_POS] = 1'b0;
    end
    if (psel_i && !penable_i && !pwrite_i) begin
      st_nxt.rdata = hit ? {st_r.cs[31], st_r.out[1], st_r.cs[29:15], st_r.out[0], st_r.cs[13:0]}
                         : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.cs <= CCR_CS_RESET;
      st_r.out <= 2'h0;
      st_r.rdata <= 32'h00000000;
      st_r.slverr <= 1'b0;
      st_r.route0 <= '0;
      st_r.route1 <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    prdata_o = st_r.rdata;
    pready_o = 1'b1;
    pslverr_o = st_r.slverr;
    first_comparator_enable_o = st_r.cs[CCR_EN_POS];
    second_comparator_enable_o = st_r.cs[CCR_HALF_POS + CCR_EN_POS];
    first_comparator_input_switch_o = st_r.cs[CCR_SW_POS];
    window_pairing_enable_o = st_r.cs[CCR_HALF_POS + CCR_WIN_POS];
    first_comparator_power_mode_o = st_r.cs[CCR_MODE_POS +: 2];
    second_comparator_power_mode_o = st_r.cs[CCR_HALF_POS + CCR_MODE_POS +: 2];
    first_comparator_negative_select_o = st_r.cs[CCR_NSEL_POS +: 3];
    second_comparator_negative_select_o = st_r.cs[CCR_HALF_POS + CCR_NSEL_POS +: 3];
    first_comparator_hysteresis_o = st_r.cs[CCR_HYST_POS +: 2];
    second_comparator_hysteresis_o = st_r.cs[CCR_HALF_POS + CCR_HYST_POS +: 2];
    first_route_o = st_r.route0;
    second_route_o = st_r.route1;
  end
endmodule : ccr_top

// ===== ccr_props.sv
// assertion checker for the comparator control register
`timescale 1ns/100ps
module ccr_props
  import ccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pslverr_o,
  input wire logic first_comparator_enable_o,
  input wire logic second_comparator_enable_o,
  input wire logic window_pairing_enable_o,
  input wire logic [1:0] second_comparator_power_mode_o,
  input wire logic [2:0] first_comparator_negative_select_o,
  input wire logic [2:0] second_comparator_negative_select_o,
  input wire logic [1:0] second_comparator_hysteresis_o,
  input wire logic [CCR_NUM_ROUTES-1:0] first_route_o,
  input wire logic [CCR_NUM_ROUTES-1:0] second_route_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic any_wr = psel_i & penable_i & pwrite_i;
  wire logic bad_wr = any_wr & (pstrb_i != 4'hf);
  wire logic [12:0] cfg = {first_comparator_enable_o, second_comparator_enable_o, window_pairing_enable_o,
    second_comparator_power_mode_o, first_comparator_negative_select_o, second_comparator_negative_select_o,
    second_comparator_hysteresis_o};
  reset_clear_a:
    assert property (disable iff (1'b0) rst_i |=> cfg == 13'h0 && first_route_o == '0 && second_route_o == '0)
    else $error("state not cleared by reset");
  strobe_err_a:
    assert property (bad_wr |-> pslverr_o) else $error("partial write not refused");
  strobe_keep_a:
    assert property (bad_wr |=> $stable(cfg)) else $error("partial write changed state");
  idle_hold_a:
    assert property (!any_wr |=> $stable(cfg)) else $error("state changed without a write");
  second_gate_a:
    assert property (second_route_o != 0 |-> $past(second_comparator_enable_o)) else $error("route while off");
  first_gate_a:
    assert property (first_route_o != 0 |-> $past(first_comparator_enable_o)) else $error("route while off");
  route_single_a:
    assert property ($onehot0(first_route_o) && $onehot0(second_route_o)) else $error("several routes active");
  nsel_legal_a:
    assert property (first_comparator_negative_select_o != CCR_NSEL_RSVD
      && second_comparator_negative_select_o != CCR_NSEL_RSVD) else $error("reserved select code held");
endmodule : ccr_props
bind ccr_top ccr_props ccr_props_i (.*);

// ===== ccr_tb_top.sv
// self-checking testbench for the comparator control register
`timescale 1ns/100ps
module ccr_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, first_cmp_raw_i = 1'b0, second_cmp_raw_i = 1'b0, err;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf;
  logic pready_o, pslverr_o, first_comparator_enable_o, second_comparator_enable_o;
  logic first_comparator_input_switch_o, window_pairing_enable_o;
  logic [1:0] first_comparator_power_mode_o, second_comparator_power_mode_o;
  logic [1:0] first_comparator_hysteresis_o, second_comparator_hysteresis_o;
  logic [2:0] first_comparator_negative_select_o, second_comparator_negative_select_o;
  logic [ccr_pkg::CCR_NUM_ROUTES-1:0] first_route_o, second_route_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  initial forever #25 clk_i = ~clk_i;
  ccr_top ccr_top_i (.*);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held from setup until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : xfer
  task automatic wr(input logic [31:0] d);
    xfer(1'b1, 12'h000, d, 4'hf);
  endtask : wr
  task automatic rdchk(input logic [31:0] exp);
    xfer(1'b0, 12'h000, 32'h0, 4'hf);
    chk(rd, exp);
  endtask : rdchk
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(32'h0);
    wr(32'h3fed3f6f);
    rdchk(32'h3fed3f6f);
    chk({first_comparator_hysteresis_o, first_comparator_input_switch_o, first_comparator_negative_select_o,
      first_comparator_power_mode_o, first_comparator_enable_o}, 32'h1f7);
    chk({second_comparator_hysteresis_o, window_pairing_enable_o, second_comparator_negative_select_o,
      second_comparator_power_mode_o, second_comparator_enable_o}, 32'h1f7);
    wr(32'h3ffd3f7f);
    rdchk(32'h3fed3f6f);
    xfer(1'b1, 12'h000, 32'h0, 4'h3);
    chk(err, 1'b1);
    rdchk(32'h3fed3f6f);
    xfer(1'b0, 12'h004, 32'h0, 4'hf);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test fields done");
    first_cmp_raw_i <= 1'b1;
    second_cmp_raw_i <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 8; c++) begin
        wr((32'(c) << 8 | 32'h1) << (16 * h));
        repeat (2) @(posedge clk_i);
        chk(h ? second_route_o : first_route_o, c == 0 ? 32'h0 : 32'h1 << (c - 1));
      end
    end
    rdchk(32'h47010000);
    wr(32'h0f010000);
    repeat (2) @(posedge clk_i);
    chk(second_route_o, 32'h0);
    wr(32'h07000000);
    repeat (2) @(posedge clk_i);
    chk(second_route_o, 32'h0);
    $display("test routing done");
    wr(32'h00008001);
    wr(32'hfffdff7f);
    rdchk(32'hff8dc001);
    wr(32'h0);
    rdchk(32'hff8dc001);
    $display("test locks done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(32'h0);
    wr(32'h00010001);
    rdchk(32'h40014001);
    $display("test reset done");
    end_of_test();
  end
endmodule : ccr_tb_top
